/* File: activity_defs.svh */
// Offsets, field positions and reset values of the interface activity monitor.
// Assumes 32-bit AHB-Lite data and one aligned word per monitor register.
`ifndef ACTIVITY_DEFS_SVH
`define ACTIVITY_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define UP_REGION        4'h0
`define DOWN_REGION      4'h1
`define REGION_MSB       11
`define REGION_LSB       8
`define INDEX_MSB        7
`define INDEX_LSB        2
`define UNMAPPED_VALUE   32'h0000_0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SNOOP_CNT_LSB    24
`define WRITE_CNT_LSB    16
`define READ_CNT_LSB     8
`define CD_BLK_BIT       7
`define CR_BLK_BIT       6
`define AC_BLK_BIT       5
`define B_BLK_BIT        4
`define W_BLK_BIT        3
`define AW_BLK_BIT       2
`define R_BLK_BIT        1
`define AR_BLK_BIT       0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define COUNT_RESET      8'h00
`define RDATA_RESET      32'h0000_0000

`endif

/* File: activity_pkg.sv */
// Types shared by the activity monitor and its per-port counter.
// Assumes nothing beyond a SystemVerilog compiler.
package activity_pkg;

  typedef logic [7:0]  count_t;
  typedef logic [31:0] word_t;

  typedef enum {
    KIND_MASTER,
    KIND_ACE,
    KIND_ACE_LITE
  } port_kind_t;

endpackage : activity_pkg

/* File: chan_activity.sv */
// Counters and stall flags of one monitored port.
// Assumes taps are synchronous to ref_clk; KIND selects the port flavour.
`timescale 1ns/1ps
`default_nettype none
`include "activity_defs.svh"

module chan_activity #(
  parameter activity_pkg::port_kind_t KIND = activity_pkg::KIND_MASTER
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  port_tap_if.mon   tap
);

  localparam bit IS_UP  = (KIND != activity_pkg::KIND_MASTER);
  localparam bit IS_ACE = (KIND == activity_pkg::KIND_ACE);

  activity_pkg::count_t rd_cnt_reg, rd_cnt_next;
  activity_pkg::count_t wr_cnt_reg, wr_cnt_next;
  activity_pkg::count_t sn_cnt_reg, sn_cnt_next;
  logic rd_inc, rd_dec, wr_inc, wr_dec, sn_inc, sn_dec;

  // --------------------------------------------------------------------------
  // In-flight counters
  // --------------------------------------------------------------------------
  always_comb begin
    rd_inc = tap.arvalid && tap.arready;
    rd_dec = IS_ACE ? tap.rack : (tap.rvalid && tap.rready && tap.rlast);
    wr_inc = tap.awvalid && tap.awready;
    wr_dec = IS_ACE ? tap.wack : (tap.bvalid && tap.bready);
    sn_inc = IS_UP && tap.acvalid && tap.acready;
    sn_dec = IS_UP && ((tap.crvalid && tap.crready && !(IS_ACE && tap.cr_data))
             || (IS_ACE && tap.cdvalid && tap.cdready && tap.cdlast));
    rd_cnt_next = 8'(rd_cnt_reg + {7'h00, rd_inc} - {7'h00, rd_dec});
    wr_cnt_next = 8'(wr_cnt_reg + {7'h00, wr_inc} - {7'h00, wr_dec});
    sn_cnt_next = 8'(sn_cnt_reg + {7'h00, sn_inc} - {7'h00, sn_dec});
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt_reg <= `COUNT_RESET;
      wr_cnt_reg <= `COUNT_RESET;
      sn_cnt_reg <= `COUNT_RESET;
    end else begin
      rd_cnt_reg <= rd_cnt_next;
      wr_cnt_reg <= wr_cnt_next;
      sn_cnt_reg <= sn_cnt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Monitor word, stall flags live from this cycle
  // --------------------------------------------------------------------------
  always_comb begin
    tap.status = 32'h0000_0000;
    tap.status[`READ_CNT_LSB +: 8]  = rd_cnt_reg;
    tap.status[`WRITE_CNT_LSB +: 8] = wr_cnt_reg;
    tap.status[`B_BLK_BIT]  = tap.bvalid  && !tap.bready;
    tap.status[`W_BLK_BIT]  = tap.wvalid  && !tap.wready;
    tap.status[`AW_BLK_BIT] = tap.awvalid && !tap.awready;
    tap.status[`R_BLK_BIT]  = tap.rvalid  && !tap.rready;
    tap.status[`AR_BLK_BIT] = tap.arvalid && !tap.arready;
    if (IS_UP) begin
      tap.status[`SNOOP_CNT_LSB +: 8] = sn_cnt_reg;
      tap.status[`CD_BLK_BIT] = IS_ACE && tap.cdvalid && !tap.cdready;
      tap.status[`CR_BLK_BIT] = tap.crvalid && !tap.crready;
      tap.status[`AC_BLK_BIT] = tap.acvalid && !tap.acready;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_read_count_up: assert property (rd_inc && !rd_dec |=>
    rd_cnt_reg == 8'($past(rd_cnt_reg) + 8'h01)) else $error("read count missed inc");
  a_write_count_down: assert property (wr_dec && !wr_inc |=>
    wr_cnt_reg == 8'($past(wr_cnt_reg) - 8'h01)) else $error("write count missed dec");
  a_snoop_count_hold: assert property (sn_inc == sn_dec |=>
    $stable(sn_cnt_reg)) else $error("snoop count moved without net change");
  a_ar_stall_flag: assert property ((tap.arvalid && !tap.arready) ==
    tap.status[`AR_BLK_BIT]) else $error("ar stall flag wrong");
  a_b_stall_flag: assert property ((tap.bvalid && !tap.bready) ==
    tap.status[`B_BLK_BIT]) else $error("b stall flag wrong");
  a_reserved_zero: assert property (!IS_UP |->
    tap.status[31:24] == 8'h00 && tap.status[7:5] == 3'h0)
    else $error("reserved monitor bits set");
  a_cd_flag_kind: assert property (tap.status[`CD_BLK_BIT] |->
    IS_ACE && tap.cdvalid && !tap.cdready) else $error("cd stall flag wrong");

  c_read_in_flight: cover property (rd_inc ##1 rd_cnt_reg != 8'h00);
  c_snoop_done:     cover property (sn_inc ##[1:20] sn_dec);
  c_both_busy:      cover property (rd_cnt_reg > 8'h01 && wr_cnt_reg > 8'h01);

endmodule : chan_activity

`default_nettype wire

/* File: interface_activity_monitor.sv */
// Top of the interface activity monitor: per-port monitors behind AHB-Lite.
// Assumes all monitored handshakes and the bus run on ref_clk; single master.
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "activity_defs.svh"

// Notes on behaviour
// - One read-only word per downstream port
// - One read-only word per upstream port
// - Bits 31:24 count snoops until response, or until the last snoop data beat on ACE ports
// - Bits 23:16 count writes until response/ack
// - Bits 15:8 count reads until response/ack
// - Bits 7:5 flag snoop data (ACE ports only), response, address stalls
// - Bits 4,3,2 flag B, W, AW stalls
// - Bits 1,0 flag R, AR stalls
// - Downstream bits 23:16 count writes in flight
// - Downstream bits 15:8 count reads in flight
// - Downstream bits 4:0 flag channel stalls
module interface_activity_monitor #(
  parameter int          NUM_UP      = 7,
  parameter int          NUM_DOWN    = 6,
  parameter logic [15:0] UP_ACE_MASK = 16'h0003
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // AHB-Lite register slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // Upstream port taps
  input  wire logic [NUM_UP-1:0]   up_arvalid,
  input  wire logic [NUM_UP-1:0]   up_arready,
  input  wire logic [NUM_UP-1:0]   up_rvalid,
  input  wire logic [NUM_UP-1:0]   up_rready,
  input  wire logic [NUM_UP-1:0]   up_rlast,
  input  wire logic [NUM_UP-1:0]   up_rack,
  input  wire logic [NUM_UP-1:0]   up_awvalid,
  input  wire logic [NUM_UP-1:0]   up_awready,
  input  wire logic [NUM_UP-1:0]   up_wvalid,
  input  wire logic [NUM_UP-1:0]   up_wready,
  input  wire logic [NUM_UP-1:0]   up_bvalid,
  input  wire logic [NUM_UP-1:0]   up_bready,
  input  wire logic [NUM_UP-1:0]   up_wack,
  input  wire logic [NUM_UP-1:0]   up_acvalid,
  input  wire logic [NUM_UP-1:0]   up_acready,
  input  wire logic [NUM_UP-1:0]   up_crvalid,
  input  wire logic [NUM_UP-1:0]   up_crready,
  input  wire logic [NUM_UP-1:0]   up_cr_data,
  input  wire logic [NUM_UP-1:0]   up_cdvalid,
  input  wire logic [NUM_UP-1:0]   up_cdready,
  input  wire logic [NUM_UP-1:0]   up_cdlast,
  // Downstream port taps
  input  wire logic [NUM_DOWN-1:0] down_arvalid,
  input  wire logic [NUM_DOWN-1:0] down_arready,
  input  wire logic [NUM_DOWN-1:0] down_rvalid,
  input  wire logic [NUM_DOWN-1:0] down_rready,
  input  wire logic [NUM_DOWN-1:0] down_rlast,
  input  wire logic [NUM_DOWN-1:0] down_awvalid,
  input  wire logic [NUM_DOWN-1:0] down_awready,
  input  wire logic [NUM_DOWN-1:0] down_wvalid,
  input  wire logic [NUM_DOWN-1:0] down_wready,
  input  wire logic [NUM_DOWN-1:0] down_bvalid,
  input  wire logic [NUM_DOWN-1:0] down_bready
);

  activity_pkg::word_t up_status   [NUM_UP];
  activity_pkg::word_t down_status [NUM_DOWN];

  // --------------------------------------------------------------------------
  // Upstream monitors
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_UP; i++) begin : g_up
    port_tap_if tap ();
    assign tap.arvalid = up_arvalid[i];
    assign tap.arready = up_arready[i];
    assign tap.rvalid  = up_rvalid[i];
    assign tap.rready  = up_rready[i];
    assign tap.rlast   = up_rlast[i];
    assign tap.rack    = up_rack[i];
    assign tap.awvalid = up_awvalid[i];
    assign tap.awready = up_awready[i];
    assign tap.wvalid  = up_wvalid[i];
    assign tap.wready  = up_wready[i];
    assign tap.bvalid  = up_bvalid[i];
    assign tap.bready  = up_bready[i];
    assign tap.wack    = up_wack[i];
    assign tap.acvalid = up_acvalid[i];
    assign tap.acready = up_acready[i];
    assign tap.crvalid = up_crvalid[i];
    assign tap.crready = up_crready[i];
    assign tap.cr_data = up_cr_data[i];
    assign tap.cdvalid = up_cdvalid[i];
    assign tap.cdready = up_cdready[i];
    assign tap.cdlast  = up_cdlast[i];
    chan_activity #(
      .KIND (UP_ACE_MASK[i] ? activity_pkg::KIND_ACE : activity_pkg::KIND_ACE_LITE)
    ) u_mon (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tap     (tap)
    );
    assign up_status[i] = tap.status;
  end

  // --------------------------------------------------------------------------
  // Downstream monitors
  // --------------------------------------------------------------------------
  for (genvar j = 0; j < NUM_DOWN; j++) begin : g_down
    port_tap_if tap ();
    assign tap.arvalid = down_arvalid[j];
    assign tap.arready = down_arready[j];
    assign tap.rvalid  = down_rvalid[j];
    assign tap.rready  = down_rready[j];
    assign tap.rlast   = down_rlast[j];
    assign tap.rack    = 1'b0;
    assign tap.awvalid = down_awvalid[j];
    assign tap.awready = down_awready[j];
    assign tap.wvalid  = down_wvalid[j];
    assign tap.wready  = down_wready[j];
    assign tap.bvalid  = down_bvalid[j];
    assign tap.bready  = down_bready[j];
    assign tap.wack    = 1'b0;
    assign tap.acvalid = 1'b0;
    assign tap.acready = 1'b0;
    assign tap.crvalid = 1'b0;
    assign tap.crready = 1'b0;
    assign tap.cr_data = 1'b0;
    assign tap.cdvalid = 1'b0;
    assign tap.cdready = 1'b0;
    assign tap.cdlast  = 1'b0;
    chan_activity #(
      .KIND (activity_pkg::KIND_MASTER)
    ) u_mon (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tap     (tap)
    );
    assign down_status[j] = tap.status;
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, reads captured at the address phase
  // --------------------------------------------------------------------------
  logic                 addr_take;
  logic [3:0]           region;
  logic [5:0]           index;
  activity_pkg::word_t  sel_word;
  activity_pkg::word_t  hrdata_reg, hrdata_next;
  logic                 hreadyout_reg, hreadyout_next;
  logic                 hresp_reg, hresp_next;

  always_comb begin
    addr_take = hsel && hready && htrans[1];
    region    = haddr[`REGION_MSB:`REGION_LSB];
    index     = haddr[`INDEX_MSB:`INDEX_LSB];
    sel_word  = `UNMAPPED_VALUE;
    for (int k = 0; k < NUM_UP; k++) begin
      if (region == `UP_REGION && index == 6'(k)) begin
        sel_word = up_status[k];
      end
    end
    for (int k = 0; k < NUM_DOWN; k++) begin
      if (region == `DOWN_REGION && index == 6'(k)) begin
        sel_word = down_status[k];
      end
    end
    if (haddr[31:12] != 20'h0_0000) begin
      sel_word = `UNMAPPED_VALUE;
    end
    hrdata_next    = hrdata_reg;
    hreadyout_next = 1'b1;
    hresp_next     = 1'b0;
    if (addr_take) begin
      // Writes are ignored: every register is read-only
      hrdata_next = hwrite ? `RDATA_RESET : sel_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_reg    <= `RDATA_RESET;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg     <= hresp_next;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_read_up_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take && !hwrite && haddr[31:8] == 24'h00_0000 && index == 6'h00
    |=> hrdata == $past(up_status[0])) else $error("upstream word not returned");
  a_read_down_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take && !hwrite && haddr[31:8] == 24'h00_0001 && index == 6'h00
    |=> hrdata == $past(down_status[0])) else $error("downstream word not returned");
  a_down_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take && !hwrite && region == `DOWN_REGION && haddr[31:12] == 20'h0_0000
    |=> hrdata[31:24] == 8'h00 && hrdata[7:5] == 3'h0)
    else $error("downstream reserved bits read non-zero");
  a_bus_no_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take |=> hreadyout && !hresp) else $error("slave stalled or erred");

  // Per-port checks against the pins
  default clocking chk_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  for (genvar p = 0; p < NUM_UP; p++) begin : g_up_chk
    // Stall flags rebuilt from the pins
    logic [7:0] up_flags;
    assign up_flags = {
      UP_ACE_MASK[p] && up_cdvalid[p] && !up_cdready[p],
      up_crvalid[p] && !up_crready[p],
      up_acvalid[p] && !up_acready[p],
      up_bvalid[p] && !up_bready[p],
      up_wvalid[p] && !up_wready[p],
      up_awvalid[p] && !up_awready[p],
      up_rvalid[p] && !up_rready[p],
      up_arvalid[p] && !up_arready[p]
    };
    a_up_snoop_flags: assert property (
      up_status[p][7:5] == up_flags[7:5])
      else $error("upstream snoop flags wrong");
    a_up_write_flags: assert property (
      up_status[p][4:2] == up_flags[4:2])
      else $error("upstream write flags wrong");
    a_up_read_flags: assert property (
      up_status[p][1:0] == up_flags[1:0])
      else $error("upstream read flags wrong");
    a_up_snoop_step: assert property (
      up_acvalid[p] && up_acready[p] && !up_crvalid[p] && !up_cdvalid[p]
      |=> up_status[p][31:24] == 8'($past(up_status[p][31:24]) + 8'h01))
      else $error("upstream snoop count missed a request");
    a_up_write_step: assert property (
      up_awvalid[p] && up_awready[p] && !up_wack[p] && !up_bvalid[p]
      |=> up_status[p][23:16] == 8'($past(up_status[p][23:16]) + 8'h01))
      else $error("upstream write count missed a request");
    a_up_word_read: assert property (
      addr_take && !hwrite && haddr[31:12] == 20'h0_0000 && region == `UP_REGION
      && index == 6'(p) |=> hrdata == $past(up_status[p]))
      else $error("upstream word not returned");
  end

  for (genvar q = 0; q < NUM_DOWN; q++) begin : g_down_chk
    // Stall flags rebuilt from the pins
    logic [4:0] down_flags;
    assign down_flags = {
      down_bvalid[q] && !down_bready[q],
      down_wvalid[q] && !down_wready[q],
      down_awvalid[q] && !down_awready[q],
      down_rvalid[q] && !down_rready[q],
      down_arvalid[q] && !down_arready[q]
    };
    a_down_flags: assert property (
      down_status[q][4:0] == down_flags)
      else $error("downstream stall flags wrong");
    a_down_unused: assert property (
      down_status[q][31:24] == 8'h00 && down_status[q][7:5] == 3'h0)
      else $error("downstream reserved field set");
    a_down_read_step: assert property (
      down_arvalid[q] && down_arready[q] && !down_rvalid[q]
      |=> down_status[q][15:8] == 8'($past(down_status[q][15:8]) + 8'h01))
      else $error("downstream read count missed a request");
    a_down_write_quiet: assert property (
      !(down_awvalid[q] && down_awready[q]) && !(down_bvalid[q] && down_bready[q])
      |=> $stable(down_status[q][23:16]))
      else $error("downstream write count moved");
    a_down_word_read: assert property (
      addr_take && !hwrite && haddr[31:12] == 20'h0_0000 && region == `DOWN_REGION
      && index == 6'(q) |=> hrdata == $past(down_status[q]))
      else $error("downstream word not returned");
  end

  // Bus answers
  a_write_reads_zero: assert property (
    addr_take && hwrite |=> hrdata == `RDATA_RESET)
    else $error("write phase read not zero");
  a_unmapped_zero: assert property (
    addr_take && (haddr[31:12] != 20'h0_0000 || region > `DOWN_REGION)
    |=> hrdata == `UNMAPPED_VALUE) else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !addr_take |=> $stable(hrdata)) else $error("read data moved without a transfer");

  c_read_up:   cover property (@(posedge ref_clk) addr_take && !hwrite && region == `UP_REGION);
  c_read_down: cover property (@(posedge ref_clk)
    addr_take && !hwrite && region == `DOWN_REGION);

endmodule : interface_activity_monitor

`default_nettype wire

/* File: interface_activity_monitor_tb.sv */
// Self-checking bench of the activity monitor: AHB-Lite reads against tap traffic.
// Assumes ports 0,1 upstream are full ACE, the others ACE-Lite; zero-wait slave.
`timescale 1ns/1ps
`default_nettype none

module interface_activity_monitor_tb;
  logic                ref_clk;
  logic                rst_n;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic [31:0]         hrdata;
  logic                hresp;
  logic [6:0]          up_tap   [21];
  logic [5:0]          down_tap [11];
  activity_pkg::word_t d;
  int                  mismatches;
  int                  checked;

  interface_activity_monitor #(.NUM_UP(7), .NUM_DOWN(6), .UP_ACE_MASK(16'h0003))
    interface_activity_monitor_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .up_arvalid(up_tap[0]), .up_arready(up_tap[1]), .up_rvalid(up_tap[2]),
    .up_rready(up_tap[3]), .up_rlast(up_tap[4]), .up_rack(up_tap[5]),
    .up_awvalid(up_tap[6]), .up_awready(up_tap[7]), .up_wvalid(up_tap[8]),
    .up_wready(up_tap[9]), .up_bvalid(up_tap[10]), .up_bready(up_tap[11]),
    .up_wack(up_tap[12]), .up_acvalid(up_tap[13]), .up_acready(up_tap[14]),
    .up_crvalid(up_tap[15]), .up_crready(up_tap[16]), .up_cr_data(up_tap[17]),
    .up_cdvalid(up_tap[18]), .up_cdready(up_tap[19]), .up_cdlast(up_tap[20]),
    .down_arvalid(down_tap[0]), .down_arready(down_tap[1]), .down_rvalid(down_tap[2]),
    .down_rready(down_tap[3]), .down_rlast(down_tap[4]), .down_awvalid(down_tap[5]),
    .down_awready(down_tap[6]), .down_wvalid(down_tap[7]), .down_wready(down_tap[8]),
    .down_bvalid(down_tap[9]), .down_bready(down_tap[10])
  );

  port_partner #(.NUM_UP(7), .NUM_DOWN(6)) port_partner_i (
    .ref_clk(ref_clk), .up_tap(up_tap), .down_tap(down_tap)
  );

  // --------------------------------------------------------------------------
  // Clock, watchdog
  // --------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  // --------------------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output activity_pkg::word_t rd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic chk(input activity_pkg::word_t seen, input activity_pkg::word_t exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rc(input logic [31:0] a, input activity_pkg::word_t exp);
    activity_pkg::word_t v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp);
    chk(32'(hresp), 32'h0);
  endtask : rc

  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  int          uv [8]  = '{0, 2, 6, 8, 10, 13, 15, 18};
  int          dv [5]  = '{0, 2, 5, 7, 9};
  logic [20:0] sm [11] = '{21'h3, 21'h1C, 21'h20, 21'h1F, 21'hC0, 21'hC00, 21'h1000,
                           21'h6000, 21'h38000, 21'h1C0000, 21'h18000};
  int          sn [11] = '{2, 1, 1, 1, 2, 1, 1, 3, 1, 1, 1};
  logic [31:0] e0 [11] = '{32'h10300, 32'h10300, 32'h10200, 32'h10300, 32'h30300,
                           32'h30300, 32'h20300, 32'h3020300, 32'h3020300, 32'h2020300,
                           32'h1020300};
  logic [31:0] e2 [11] = '{32'h300, 32'h200, 32'h200, 32'h200, 32'h20200, 32'h10200,
                           32'h10200, 32'h3010200, 32'h2010200, 32'h2010200, 32'h1010200};

  initial begin
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rc(32'(4 * i), 32'h0);
    for (int i = 0; i < 6; i++) rc(32'h100 + 32'(4 * i), 32'h0);
    // Each channel stalled, then completed by a ready pulse
    for (int k = 0; k < 8; k++) begin
      port_partner_i.set_lines(1'b1, 8'h05, 21'h1 << uv[k], 1'b1);
      bus(1'b0, 32'h000, 32'h0, d);
      chk(d & 32'hFF, 32'h1 << k);
      bus(1'b0, 32'h008, 32'h0, d);
      chk(d & 32'hFF, (k == 7) ? 32'h0 : 32'h1 << k);
      port_partner_i.pulse(1'b1, 8'h05, 21'h3 << uv[k], 1);
    end
    rc(32'h000, 32'h0001_0100);
    rc(32'h008, 32'h0000_0100);
    for (int k = 0; k < 5; k++) begin
      port_partner_i.set_lines(1'b0, 8'h21, 21'h1 << dv[k], 1'b1);
      bus(1'b0, 32'h114, 32'h0, d);
      chk(d & 32'hFF, 32'h1 << k);
      port_partner_i.pulse(1'b0, 8'h21, 21'h3 << dv[k], 1);
    end
    rc(32'h100, 32'h0000_0100);
    // Counter walk on an ACE and an ACE-Lite port side by side
    for (int k = 0; k < 11; k++) begin
      port_partner_i.pulse(1'b1, (k == 9) ? 8'h01 : 8'h05, sm[k], sn[k]);
      rc(32'h000, e0[k]);
      rc(32'h008, e2[k]);
    end
    bus(1'b1, 32'h000, 32'hFFFF_FFFF, d);
    chk(d, 32'h0);
    rc(32'h000, 32'h0102_0300);
    rc(32'h01C, 32'h0);
    rc(32'h200, 32'h0);
    port_partner_i.pulse(1'b1, 8'h08, 21'hC00, 1);
    rc(32'h00C, 32'h00FF_0000);
    port_partner_i.pulse(1'b0, 8'h21, 21'h3, 2);
    port_partner_i.pulse(1'b0, 8'h21, 21'h1C, 1);
    rc(32'h114, 32'h0000_0200);
    port_partner_i.pulse(1'b0, 8'h21, 21'h60, 2);
    port_partner_i.pulse(1'b0, 8'h21, 21'h600, 1);
    rc(32'h100, 32'h0001_0200);
    rc(32'h114, 32'h0001_0200);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(32'h000, 32'h0);
    rc(32'h100, 32'h0);
    end_sim();
  end
endmodule : interface_activity_monitor_tb

`default_nettype wire

/* File: port_partner.sv */
// Far-side model: the masters and slaves whose handshakes the monitor watches.
// Assumes ref_clk is the monitor's clock; lines change only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module port_partner #(
  parameter int NUM_UP   = 7,
  parameter int NUM_DOWN = 6
) (
  input  wire logic                ref_clk,
  output var  logic [NUM_UP-1:0]   up_tap   [21],
  output var  logic [NUM_DOWN-1:0] down_tap [11]
);
  // --------------------------------------------------------------------------
  // Idle lines
  // --------------------------------------------------------------------------
  initial begin
    foreach (up_tap[i]) up_tap[i] = '0;
    foreach (down_tap[i]) down_tap[i] = '0;
  end

  // --------------------------------------------------------------------------
  // Line control: m picks tap lines, pm picks ports
  // --------------------------------------------------------------------------
  task automatic set_lines(input bit up, input logic [7:0] pm, input logic [20:0] m,
                           input logic v);
    @(posedge ref_clk);
    for (int i = 0; i < 21; i++) begin
      if (m[i] && up) begin
        up_tap[i] <= v ? up_tap[i] | pm[NUM_UP-1:0] : up_tap[i] & ~pm[NUM_UP-1:0];
      end else if (m[i] && i < 11) begin
        down_tap[i] <= v ? down_tap[i] | pm[NUM_DOWN-1:0] : down_tap[i] & ~pm[NUM_DOWN-1:0];
      end
    end
  endtask : set_lines

  // Lines high for exactly n cycles
  task automatic pulse(input bit up, input logic [7:0] pm, input logic [20:0] m, input int n);
    set_lines(up, pm, m, 1'b1);
    repeat (n - 1) @(posedge ref_clk);
    set_lines(up, pm, m, 1'b0);
  endtask : pulse
endmodule : port_partner

`default_nettype wire

/* File: port_tap_if.sv */
// Handshake taps of one monitored port and the monitor word built from them.
// Assumes all taps are on ref_clk.
`timescale 1ns/1ps
`default_nettype none

interface port_tap_if;
  logic                  arvalid, arready, rvalid, rready, rlast, rack;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready, wack;
  logic                  acvalid, acready, crvalid, crready, cr_data;
  logic                  cdvalid, cdready, cdlast;
  activity_pkg::word_t   status;

  modport mon (
    input  arvalid, arready, rvalid, rready, rlast, rack,
    input  awvalid, awready, wvalid, wready, bvalid, bready, wack,
    input  acvalid, acready, crvalid, crready, cr_data,
    input  cdvalid, cdready, cdlast,
    output status
  );
  modport src (
    output arvalid, arready, rvalid, rready, rlast, rack,
    output awvalid, awready, wvalid, wready, bvalid, bready, wack,
    output acvalid, acready, crvalid, crready, cr_data,
    output cdvalid, cdready, cdlast,
    input  status
  );
endinterface : port_tap_if

`default_nettype wire
